// >>> hdl/oss_sample_fifo.sv
// Sample buffer, pointer logic and core control registers of the optical sensor
`default_nettype none
module oss_sample_fifo
  import oss_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          link_clk_i,
  input  wire logic          link_req_valid_i,
  input  wire oss_link_req_t link_req_i,
  output logic               link_req_ready_o,
  output logic [7:0]         link_rdata_o,
  output logic               link_rvalid_o,
  input  wire logic          sample_valid_i,
  input  wire oss_sample_t   sample_i,
  input  wire logic [1:0]    chan_last_i,
  input  wire logic          uvlo_i,
  output logic               power_save_o,
  output logic [2:0]         op_mode_o,
  output logic [1:0]         adc_range_o,
  output logic               almost_full_o,
  output logic               power_ready_event_o
);

  // ---------------------------------------------------------------------
  // Link domain: capture request, toggle across, wait for answer
  // ---------------------------------------------------------------------
  oss_link_req_t link_cmd_q;
  logic          link_tog_q;
  logic          link_busy_q;
  logic          l_ack_s1_q;
  logic          l_ack_s2_q;
  logic          l_ack_s3_q;
  logic [7:0]    link_rdata_q;
  logic          link_rvalid_q;
  logic          core_ack_tog_q;
  logic [7:0]    core_rdata_q;
  logic          l_ack_evt;

  assign l_ack_evt        = l_ack_s2_q ^ l_ack_s3_q;
  assign link_req_ready_o = ~link_busy_q;
  assign link_rdata_o     = link_rdata_q;
  assign link_rvalid_o    = link_rvalid_q;

  // Command stays frozen while busy, so the core may sample it freely
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_cmd_q  <= '{kind: CMD_SET_ADDR, data: RESET_BYTE};
      link_tog_q  <= 1'b0;
      link_busy_q <= 1'b0;
    end else if (link_req_valid_i && !link_busy_q) begin
      link_cmd_q  <= link_req_i;
      link_tog_q  <= ~link_tog_q;
      link_busy_q <= 1'b1;
    end else if (l_ack_evt) begin
      link_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      l_ack_s1_q <= 1'b0;
      l_ack_s2_q <= 1'b0;
      l_ack_s3_q <= 1'b0;
    end else begin
      l_ack_s1_q <= core_ack_tog_q;
      l_ack_s2_q <= l_ack_s1_q;
      l_ack_s3_q <= l_ack_s2_q;
    end
  end

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_rdata_q  <= RESET_BYTE;
      link_rvalid_q <= 1'b0;
    end else begin
      link_rvalid_q <= l_ack_evt && (link_cmd_q.kind == CMD_READ);
      if (l_ack_evt && (link_cmd_q.kind == CMD_READ)) begin
        link_rdata_q <= core_rdata_q;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Core domain: synchronisers
  // ---------------------------------------------------------------------
  logic c_req_s1_q;
  logic c_req_s2_q;
  logic c_req_s3_q;
  logic uvlo_s1_q;
  logic uvlo_s2_q;
  logic uvlo_s3_q;
  logic c_evt;
  logic uvlo_rel;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c_req_s1_q <= 1'b0;
      c_req_s2_q <= 1'b0;
      c_req_s3_q <= 1'b0;
      uvlo_s1_q  <= 1'b0;
      uvlo_s2_q  <= 1'b0;
      uvlo_s3_q  <= 1'b0;
    end else begin
      c_req_s1_q <= link_tog_q;
      c_req_s2_q <= c_req_s1_q;
      c_req_s3_q <= c_req_s2_q;
      uvlo_s1_q  <= uvlo_i;
      uvlo_s2_q  <= uvlo_s1_q;
      uvlo_s3_q  <= uvlo_s2_q;
    end
  end

  assign c_evt    = c_req_s2_q ^ c_req_s3_q;
  assign uvlo_rel = uvlo_s3_q & ~uvlo_s2_q;

  // ---------------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------------
  logic [7:0]       addr_q;
  logic             op_set;
  logic             op_wr;
  logic             op_rd;
  logic             wr_wr_idx;
  logic             wr_lost;
  logic             wr_rd_idx;
  logic             wr_buf_cfg;
  logic             wr_mode;
  logic             wr_conv;
  logic             rd_status;
  logic             rd_data;
  logic [7:0]       buf_cfg_q;
  logic             ps_q;
  logic             srst_q;
  logic [2:0]       mode_q;
  logic [CONV_HI:0] conv_cfg_q;
  logic             idx_wr_ok;

  assign op_set     = c_evt && (link_cmd_q.kind == CMD_SET_ADDR);
  assign op_wr      = c_evt && (link_cmd_q.kind == CMD_WRITE);
  assign op_rd      = c_evt && (link_cmd_q.kind == CMD_READ);
  assign idx_wr_ok  = (mode_q == MODE_HR) || (mode_q == MODE_DUAL)
                    || (mode_q == MODE_MULTI);
  assign wr_wr_idx  = op_wr && (addr_q == ADDR_WR_IDX) && idx_wr_ok;
  assign wr_lost    = op_wr && (addr_q == ADDR_LOST);
  assign wr_rd_idx  = op_wr && (addr_q == ADDR_RD_IDX);
  assign wr_buf_cfg = op_wr && (addr_q == ADDR_BUF_CFG);
  assign wr_mode    = op_wr && (addr_q == ADDR_MODE);
  assign wr_conv    = op_wr && (addr_q == ADDR_CONV_CFG);
  assign rd_status  = op_rd && (addr_q == ADDR_STATUS);
  assign rd_data    = op_rd && (addr_q == ADDR_DATA);

  // Data register holds the address; 0xFF sticks instead of wrapping
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= RESET_BYTE;
    end else if (op_set) begin
      addr_q <= link_cmd_q.data;
    end else if ((op_rd || op_wr) && (addr_q != ADDR_DATA)
                 && (addr_q != ADDR_LAST)) begin
      addr_q <= addr_q + ADDR_STEP;
    end
  end

  // ---------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_cfg_q  <= RESET_BYTE;
      ps_q       <= 1'b0;
      mode_q     <= RESET_BYTE[2:0];
      conv_cfg_q <= RESET_BYTE[CONV_HI:0];
      srst_q     <= 1'b0;
    end else if (srst_q) begin
      buf_cfg_q  <= RESET_BYTE;
      ps_q       <= 1'b0;
      mode_q     <= RESET_BYTE[2:0];
      conv_cfg_q <= RESET_BYTE[CONV_HI:0];
      srst_q     <= 1'b0;
    end else begin
      if (wr_buf_cfg) begin
        buf_cfg_q <= link_cmd_q.data;
      end
      if (wr_mode) begin
        ps_q   <= link_cmd_q.data[PS_BIT];
        srst_q <= link_cmd_q.data[SRST_BIT];
        mode_q <= link_cmd_q.data[MODE_HI:0];
      end
      if (wr_conv) begin
        conv_cfg_q <= link_cmd_q.data[CONV_HI:0];
      end
    end
  end

  assign power_save_o = ps_q;
  assign op_mode_o    = mode_q;
  assign adc_range_o  = conv_cfg_q[RANGE_HI:RANGE_LO];

  // ---------------------------------------------------------------------
  // Averaging and decimation per channel
  // ---------------------------------------------------------------------
  logic [2:0]              avg_sh;
  logic [5:0]              avg_last;
  logic [5:0]              avg_cnt_q;
  logic                    avg_done;
  logic [NCH-1:0][ACC_W-1:0] acc_q;
  oss_sample_t             avg_word;
  logic                    take;

  assign avg_sh   = (buf_cfg_q[AVG_HI:AVG_LO] > AVG_SH_MAX) ? AVG_SH_MAX
                  : buf_cfg_q[AVG_HI:AVG_LO];
  assign avg_last = 6'((7'h01 << avg_sh) - 7'h01);
  assign take     = sample_valid_i && !ps_q;
  assign avg_done = take && (avg_cnt_q == avg_last);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avg_cnt_q <= DEPTH_CNT - DEPTH_CNT;
    end else if (srst_q || avg_done) begin
      avg_cnt_q <= DEPTH_CNT - DEPTH_CNT;
    end else if (take) begin
      avg_cnt_q <= avg_cnt_q + 6'h01;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_avg
    logic [ACC_W-1:0] sum;
    assign sum         = acc_q[c] + ACC_W'(sample_i[c]);
    assign avg_word[c] = ADC_W'(sum >> avg_sh);
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        acc_q[c] <= '0;
      end else if (srst_q || avg_done) begin
        acc_q[c] <= '0;
      end else if (take) begin
        acc_q[c] <= sum;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Buffer pointers, full flag and lost counter
  // ---------------------------------------------------------------------
  logic [IDX_W-1:0] wr_q;
  logic [IDX_W-1:0] wr_d;
  logic [IDX_W-1:0] rd_q;
  logic [IDX_W-1:0] rd_d;
  logic [IDX_W-1:0] held_q;
  logic [4:0]       lost_q;
  logic [4:0]       lost_d;
  logic             full_q;
  logic             full_d;
  logic             empty;
  logic             first_byte;
  logic             rd_adv;
  logic             store;
  logic [5:0]       cnt_d;
  logic             af_set;
  logic [1:0]       chan_q;
  logic [1:0]       part_q;

  assign empty      = (wr_q == rd_q) && !full_q;
  assign first_byte = (chan_q == '0) && (part_q == '0);
  assign rd_adv     = rd_data && first_byte && !empty;

  always_comb begin
    wr_d   = wr_q;
    rd_d   = rd_q;
    full_d = full_q;
    lost_d = lost_q;
    store  = 1'b0;
    if (rd_adv) begin
      rd_d   = rd_q + IDX_STEP;
      full_d = 1'b0;
      lost_d = LOST_MAX & IDX_ZERO;
    end
    if (avg_done) begin
      if (!full_q || rd_adv) begin
        store  = 1'b1;
        wr_d   = wr_q + IDX_STEP;
        full_d = (wr_d == rd_d);
      end else if (buf_cfg_q[ROLL_BIT]) begin
        // Oldest sample is overwritten, so the read side moves with it
        store = 1'b1;
        wr_d  = wr_q + IDX_STEP;
        rd_d  = wr_q + IDX_STEP;
      end else if (lost_q != LOST_MAX) begin
        lost_d = lost_q + IDX_STEP;
      end
    end
    if (wr_wr_idx) begin
      wr_d   = link_cmd_q.data[IDX_W-1:0];
      full_d = 1'b0;
    end
    if (wr_rd_idx) begin
      rd_d   = link_cmd_q.data[IDX_W-1:0];
      full_d = 1'b0;
    end
    if (wr_lost) begin
      lost_d = link_cmd_q.data[4:0];
    end
    if (srst_q || uvlo_s2_q) begin
      wr_d   = IDX_ZERO;
      rd_d   = IDX_ZERO;
      full_d = 1'b0;
      lost_d = IDX_ZERO;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q   <= IDX_ZERO;
      rd_q   <= IDX_ZERO;
      full_q <= 1'b0;
      lost_q <= IDX_ZERO;
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      full_q <= full_d;
      lost_q <= lost_d;
    end
  end

  assign cnt_d  = full_d ? DEPTH_CNT : {1'b0, wr_d - rd_d};
  assign af_set = store && ((DEPTH_CNT - cnt_d) == {2'b00, buf_cfg_q[AFULL_HI:0]});

  // ---------------------------------------------------------------------
  // Sample memory and byte sequencing
  // ---------------------------------------------------------------------
  oss_sample_t       mem [DEPTH];
  logic [IDX_W-1:0]  src_idx;
  logic [ADC_W-1:0]  cur_word;
  logic [23:0]       cur_word24;
  logic [7:0]        data_byte;

  always_ff @(posedge clk_i) begin
    if (store) begin
      mem[wr_q] <= avg_word;
    end
  end

  assign src_idx    = first_byte ? rd_q : held_q;
  assign cur_word   = mem[src_idx][chan_q];
  assign cur_word24 = {{PAD_W{1'b0}}, cur_word};

  always_comb begin
    unique case (part_q)
      2'h0:    data_byte = cur_word24[23:16];
      2'h1:    data_byte = cur_word24[15:8];
      2'h2:    data_byte = cur_word24[7:0];
      default: data_byte = RESET_BYTE;
    endcase
  end

  // Sequencing restarts on a new address or any pointer rewrite
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chan_q <= '0;
      part_q <= '0;
      held_q <= IDX_ZERO;
    end else if (srst_q || uvlo_s2_q || op_set || wr_wr_idx || wr_rd_idx) begin
      chan_q <= '0;
      part_q <= '0;
    end else if (rd_data) begin
      if (first_byte) begin
        held_q <= rd_q;
      end
      if (part_q == PART_LAST) begin
        part_q <= '0;
        chan_q <= (chan_q == chan_last_i) ? 2'h0 : chan_q + 2'h1;
      end else begin
        part_q <= part_q + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------
  logic af_q;
  logic pwr_q;

  // A new event wins over a status read in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      af_q <= 1'b0;
    end else if (srst_q || ps_q) begin
      af_q <= 1'b0;
    end else if (af_set) begin
      af_q <= 1'b1;
    end else if (rd_status) begin
      af_q <= 1'b0;
    end
  end

  // Soft reset leaves this flag alone; only reset and supply recovery raise it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_q <= 1'b1;
    end else if (uvlo_rel) begin
      pwr_q <= 1'b1;
    end else if (rd_status || ps_q) begin
      pwr_q <= 1'b0;
    end
  end

  assign almost_full_o       = af_q;
  assign power_ready_event_o = pwr_q;

  // ---------------------------------------------------------------------
  // Read answer and acknowledge toggle
  // ---------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    unique case (addr_q)
      ADDR_STATUS:   rd_mux = {af_q, 6'h00, pwr_q};
      ADDR_WR_IDX:   rd_mux = {3'h0, wr_q};
      ADDR_LOST:     rd_mux = {3'h0, lost_q};
      ADDR_RD_IDX:   rd_mux = {3'h0, rd_q};
      ADDR_DATA:     rd_mux = data_byte;
      ADDR_BUF_CFG:  rd_mux = buf_cfg_q;
      ADDR_MODE:     rd_mux = {ps_q, srst_q, 3'h0, mode_q};
      ADDR_CONV_CFG: rd_mux = {1'b0, conv_cfg_q};
      default:       rd_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_rdata_q   <= RESET_BYTE;
      core_ack_tog_q <= 1'b0;
    end else if (c_evt) begin
      if (op_rd) begin
        core_rdata_q <= rd_mux;
      end
      core_ack_tog_q <= ~core_ack_tog_q;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/oss_pkg.sv
// Package of constants and types for the optical sensor sample buffer
`default_nettype none
package oss_pkg;
  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_WR_IDX    = 8'h04;
  localparam logic [7:0] ADDR_LOST      = 8'h05;
  localparam logic [7:0] ADDR_RD_IDX    = 8'h06;
  localparam logic [7:0] ADDR_DATA      = 8'h07;
  localparam logic [7:0] ADDR_BUF_CFG   = 8'h08;
  localparam logic [7:0] ADDR_MODE      = 8'h09;
  localparam logic [7:0] ADDR_CONV_CFG  = 8'h0A;
  localparam logic [7:0] ADDR_LAST      = 8'hFF;
  localparam logic [7:0] ADDR_STEP      = 8'h01;

  // ---------------------------------------------------------------------
  // Buffer geometry
  // ---------------------------------------------------------------------
  localparam int         DEPTH          = 32;
  localparam int         IDX_W          = 5;
  localparam int         NCH            = 4;
  localparam int         ADC_W          = 18;
  localparam int         ACC_W          = 23;
  localparam int         PAD_W          = 6;
  localparam logic [5:0] DEPTH_CNT      = 6'h20;
  localparam logic [4:0] LOST_MAX       = 5'h1F;
  localparam logic [4:0] IDX_ZERO       = 5'h00;
  localparam logic [4:0] IDX_STEP       = 5'h01;
  localparam logic [1:0] PART_LAST      = 2'h2;
  localparam logic [2:0] AVG_SH_MAX     = 3'h5;

  // ---------------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------------
  localparam int         AVG_HI         = 7;
  localparam int         AVG_LO         = 5;
  localparam int         ROLL_BIT       = 4;
  localparam int         AFULL_HI       = 3;
  localparam int         PS_BIT         = 7;
  localparam int         SRST_BIT       = 6;
  localparam int         MODE_HI        = 2;
  localparam int         RANGE_HI       = 6;
  localparam int         RANGE_LO       = 5;
  localparam int         CONV_HI        = 6;
  localparam logic [2:0] MODE_HR        = 3'h2;
  localparam logic [2:0] MODE_DUAL      = 3'h3;
  localparam logic [2:0] MODE_MULTI     = 3'h7;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  typedef enum logic [1:0] {
    CMD_SET_ADDR = 2'b00,
    CMD_WRITE    = 2'b01,
    CMD_READ     = 2'b10
  } oss_cmd_kind_t;

  typedef struct packed {
    oss_cmd_kind_t kind;
    logic [7:0]    data;
  } oss_link_req_t;

  typedef logic [NCH-1:0][ADC_W-1:0] oss_sample_t;
endpackage
`default_nettype wire

// >>> test/oss_sample_fifo_properties.sv
// Port checks for the sample buffer
`default_nettype none
module oss_fifo_checker
  import oss_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          resetn_i,
  input wire logic          link_clk_i,
  input wire logic          link_req_valid_i,
  input wire oss_link_req_t link_req_i,
  input wire logic          link_req_ready_o,
  input wire logic [7:0]    link_rdata_o,
  input wire logic          link_rvalid_o,
  input wire logic          sample_valid_i,
  input wire oss_sample_t   sample_i,
  input wire logic [1:0]    chan_last_i,
  input wire logic          uvlo_i,
  input wire logic          power_save_o,
  input wire logic [2:0]    op_mode_o,
  input wire logic [1:0]    adc_range_o,
  input wire logic          almost_full_o,
  input wire logic          power_ready_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  take_busy_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    link_req_valid_i && link_req_ready_o |=> !link_req_ready_o) else $error("ready after take");
  answer_bound_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    $fell(link_req_ready_o) |-> ##[1:24] link_req_ready_o) else $error("no answer");
  rvalid_pulse_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    link_rvalid_o |=> !link_rvalid_o) else $error("rvalid too long");
  rvalid_ready_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    link_rvalid_o |-> link_req_ready_o) else $error("rvalid while busy");
  rdata_hold_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    !link_rvalid_o |-> $stable(link_rdata_o)) else $error("rdata moved");
  afull_cause_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(almost_full_o) |-> $past(sample_valid_i)) else $error("almost full without store");
  pready_cause_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(power_ready_event_o) |-> $past(uvlo_i, 2) || $past(uvlo_i, 3) || $past(uvlo_i, 4)
    || $past(uvlo_i, 5)) else $error("power ready without lockout");
  psave_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    power_save_o && $past(power_save_o) |-> !almost_full_o && !power_ready_event_o)
    else $error("event during power save");
endmodule
bind oss_sample_fifo oss_fifo_checker u_chk (.*);
`default_nettype wire

// >>> test/oss_host_model.sv
// Link-side host model issuing register requests
`default_nettype none
module oss_host_model
  import oss_pkg::*;
(
  input  wire logic         link_clk_i,
  input  wire logic         ready_i,
  input  wire logic         rvalid_i,
  input  wire logic [7:0]   rdata_i,
  output var logic          valid_o,
  output var oss_link_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_timeouts = 0;
  initial begin
    valid_o = 1'b0;
    req_o   = '{CMD_SET_ADDR, 8'h00};
  end
  // One request at a time; released data shows its inverse
  task automatic xfer(input oss_cmd_kind_t k, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge link_clk_i);
    valid_o <= 1'b1;
    req_o   <= '{k, d};
    do @(posedge link_clk_i); while (!ready_i);
    valid_o    <= 1'b0;
    req_o.data <= ~d;
    do begin
      @(posedge link_clk_i);
      n++;
    end while (!(k == CMD_READ ? rvalid_i : ready_i) && n < 60);
    if (n >= 60)
      n_timeouts++;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Bench for the sample buffer with a queue reference
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oss_pkg::*;
  logic          clk_i, resetn_i, link_clk_i, link_req_valid_i, link_req_ready_o, uvlo_i;
  logic          link_rvalid_o, sample_valid_i, power_save_o, almost_full_o;
  logic          power_ready_event_o;
  logic [1:0]    chan_last_i, adc_range_o;
  logic [2:0]    op_mode_o;
  logic [7:0]    link_rdata_o, q;
  logic [7:0]    cv[3] = '{8'h01, 8'h02, 8'h20};
  logic [2:0]    md[3] = '{MODE_HR, MODE_DUAL, MODE_MULTI};
  bit            roll;
  oss_link_req_t link_req_i;
  oss_sample_t   sample_i, lastv;
  oss_sample_t   mq[$];
  int            n_errors, cmp_count, lost;
  oss_sample_fifo dut (.*);
  oss_host_model host (.link_clk_i, .ready_i(link_req_ready_o), .rvalid_i(link_rvalid_o),
    .rdata_i(link_rdata_o), .valid_o(link_req_valid_i), .req_o(link_req_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #24 link_clk_i = ~link_clk_i;
  end
  initial begin
    #500us;
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    n_errors += host.n_timeouts;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(CMD_SET_ADDR, a, q);
    host.xfer(CMD_READ, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(CMD_SET_ADDR, a, q);
    host.xfer(CMD_WRITE, d, q);
  endtask
  // Reference drops samples once 32 are unread
  task automatic push(input int n, input bit st);
    oss_sample_t v;
    repeat (n) begin
      v = oss_sample_t'({$urandom, $urandom, $urandom});
      @(posedge clk_i);
      sample_valid_i <= 1'b1;
      sample_i       <= v;
      if (st && roll && mq.size() == DEPTH)
        void'(mq.pop_front());
      if (st && mq.size() < DEPTH)
        mq.push_back(v);
      else if (st && lost < 31)
        lost++;
    end
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rd_smp();
    host.xfer(CMD_SET_ADDR, ADDR_DATA, q);
    lastv = mq.pop_front();
    for (int c = 0; c < 2; c++)
      for (int b = 2; b >= 0; b--) begin
        host.xfer(CMD_READ, 8'h00, q);
        chk(q, 8'({6'h00, lastv[c]} >> (8 * b)));
      end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h93e8));
    {resetn_i, sample_valid_i, uvlo_i} = 3'h0;
    sample_i    = '0;
    chan_last_i = 2'h1;
    repeat (12) @(posedge clk_i);
    chk({7'h00, power_ready_event_o}, 8'h01);
    resetn_i <= 1'b1;
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_WR_IDX, 8'h05);
    rd(ADDR_WR_IDX, 8'h00);
    foreach (md[i]) begin
      wr(ADDR_MODE, {5'h00, md[i]});
      wr(ADDR_WR_IDX, 8'(i + 3));
      rd(ADDR_WR_IDX, 8'(i + 3));
    end
    wr(ADDR_WR_IDX, RESET_BYTE);
    wr(ADDR_LOST, RESET_BYTE);
    wr(ADDR_RD_IDX, RESET_BYTE);
    host.xfer(CMD_SET_ADDR, ADDR_BUF_CFG, q);
    foreach (cv[i]) host.xfer(CMD_WRITE, cv[i], q);
    host.xfer(CMD_SET_ADDR, ADDR_BUF_CFG, q);
    foreach (cv[i]) begin
      host.xfer(CMD_READ, 8'h00, q);
      chk(q, cv[i]);
    end
    chk({6'h00, adc_range_o}, 8'h01);
    push(5, 1'b1);
    rd(ADDR_WR_IDX, 8'h05);
    rd_smp();
    rd_smp();
    rd(ADDR_RD_IDX, 8'h02);
    wr(ADDR_RD_IDX, 8'h01);
    mq.push_front(lastv);
    rd_smp();
    push(27, 1'b1);
    chk({7'h00, almost_full_o}, 8'h00);
    push(1, 1'b1);
    chk({7'h00, almost_full_o}, 8'h01);
    push(41, 1'b1);
    rd(ADDR_LOST, 8'(lost));
    rd_smp();
    rd(ADDR_LOST, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    chk({7'h00, almost_full_o}, 8'h00);
    wr(ADDR_MODE, {5'h00, MODE_DUAL});
    chk({5'h00, op_mode_o}, {5'h00, MODE_DUAL});
    rd(ADDR_BUF_CFG, 8'h01);
    rd_smp();
    @(posedge clk_i);
    uvlo_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    uvlo_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({7'h00, power_ready_event_o}, 8'h01);
    rd(ADDR_WR_IDX, 8'h00);
    mq.delete();
    wr(ADDR_BUF_CFG, 8'h20);
    push(2, 1'b1);
    for (int c = 0; c < NCH; c++)
      lastv[c] = ADC_W'((24'(mq[0][c]) + 24'(mq[1][c])) >> 1);
    mq.delete();
    mq.push_back(lastv);
    rd_smp();
    roll = 1'b1;
    wr(ADDR_BUF_CFG, 8'h10);
    push(33, 1'b1);
    rd(ADDR_WR_IDX, 8'h02);
    rd(ADDR_LOST, 8'h00);
    rd_smp();
    wr(ADDR_MODE, 8'h83);
    chk({7'h00, power_ready_event_o}, 8'h00);
    chk({7'h00, power_save_o}, 8'h01);
    push(3, 1'b0);
    rd(ADDR_WR_IDX, 8'h02);
    wr(ADDR_MODE, 8'h40);
    rd(ADDR_MODE, 8'h00);
    rd(ADDR_BUF_CFG, 8'h00);
    chk({7'h00, power_ready_event_o}, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
